// *** rtl/rdd_pkg.sv ***
// Purpose: constants for the receive descriptor dma
// Assumes: 32-bit host memory, byte addressed, little endian
// Notes:   register offsets are byte addresses on the wishbone slave
package rdd_pkg;
  // descriptor layout
  localparam logic [31:0] DESC_LINK_OFF  = 32'h0000_0004;
  localparam logic [31:0] DESC_SIZE_OFF  = 32'h0000_000C;
  localparam logic [31:0] DESC_DATA_OFF  = 32'h0000_0010;
  localparam int          BIT_LAST       = 31;
  localparam int          BIT_SUSPEND    = 30;
  localparam int          BIT_HEADER     = 20;
  localparam int          BIT_DONE       = 15;
  localparam int          BIT_OK         = 13;
  localparam int          BIT_NO_ROOM    = 9;
  localparam int          BIT_RX_ERR     = 4;
  localparam int          BIT_DATA_DONE  = 15;
  localparam int          BIT_CNT_VALID  = 14;
  localparam int          SIZE_LSB       = 16;
  localparam int          CNT_W          = 14;
  localparam int          STAT_W         = 13;
  localparam logic [3:0]  SEL_LOW_HALF   = 4'h3;
  localparam logic [3:0]  SEL_ALL        = 4'hF;
  // register map
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_BASE       = 8'h04;
  localparam logic [7:0]  REG_FIRST      = 8'h08;
  localparam logic [7:0]  REG_HDR        = 8'h0C;
  localparam logic [7:0]  REG_STATE      = 8'h10;
  localparam logic [7:0]  REG_FRAMES     = 8'h14;
  localparam logic [7:0]  REG_DROPS      = 8'h18;
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_RESUME    = 1;
  localparam int          CTRL_ABORT     = 2;
  localparam int          CTRL_HDR_LOAD  = 3;
  // receive unit state as seen by software
  localparam logic [1:0]  RX_IDLE        = 2'h0;
  localparam logic [1:0]  RX_SUSPENDED   = 2'h1;
  localparam logic [1:0]  RX_NO_RES      = 2'h2;
  localparam logic [1:0]  RX_READY       = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_RD_CMD   = 4'h1,
    ST_RD_LINK  = 4'h2,
    ST_RD_SIZE  = 4'h3,
    ST_RECV     = 4'h4,
    ST_WR_DATA  = 4'h5,
    ST_WR_COUNT = 4'h6,
    ST_WR_STAT  = 4'h7,
    ST_SUSP     = 4'h8,
    ST_NORES    = 4'h9
  } rdd_state_t;
endpackage

// *** rtl/rdd_packer.sv ***
// Purpose: packs received bytes into little-endian 32-bit words
// Assumes: in_valid only while out_valid is low
// Notes:   a word with sel zero marks a frame end with nothing to store
module rdd_packer
  import rdd_pkg::*;
#(
  parameter int LANES = 4
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               in_valid_i,
  input  wire logic [7:0]         in_data_i,
  input  wire logic               in_keep_i,
  input  wire logic               in_last_i,
  input  wire logic               out_ready_i,
  output logic                    out_valid_o,
  output logic                    out_last_o,
  output logic [LANES*8-1:0]      out_word_o,
  output logic [LANES-1:0]        out_sel_o,
  output logic                    almost_o
);
  logic [$clog2(LANES)-1:0] lane;
  logic                     put;

  assign put      = in_valid_i && !out_valid_o && in_keep_i;
  assign almost_o = (lane == $clog2(LANES)'(LANES - 1));

  ////////////////////////////////////////////////////////////////////////
  // byte lanes
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_word_o[g*8 +: 8] <= 8'h00;
        out_sel_o[g]         <= 1'b0;
      end else if (out_valid_o && out_ready_i) begin
        out_sel_o[g] <= 1'b0;
      end else if (put && lane == $clog2(LANES)'(g)) begin
        out_word_o[g*8 +: 8] <= in_data_i;
        out_sel_o[g]         <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane pointer and word hand-off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane        <= '0;
      out_valid_o <= 1'b0;
      out_last_o  <= 1'b0;
    end else if (out_valid_o && out_ready_i) begin
      lane        <= '0;
      out_valid_o <= 1'b0;
      out_last_o  <= 1'b0;
    end else if (in_valid_i && !out_valid_o) begin
      if (put) begin
        lane <= lane + 1'b1;
      end
      if (in_last_i || (put && almost_o)) begin
        out_valid_o <= 1'b1;
        out_last_o  <= in_last_i;
      end
    end
  end
endmodule

// *** rtl/rdd_receive_dma.sv ***
// Purpose: receive descriptor dma, simplified memory model
// Assumes: host memory reached as a classic wishbone master, frames as bytes
// Notes:   registers on a classic wishbone slave
// Behaviour
// - a descriptor with bit 31 set is the final free list entry.
// - bit 30 set suspends the receive unit after that frame.
// - bit 20 marks a header descriptor, honoured only after header size load.
// - bit 15 completion is set when the frame reception finishes.
// - bit 13 no-error set only for error free, fully stored frames.
// - a fitting frame in the last descriptor still gets no-error.
// - after the last descriptor, enter no-resource and pulse the interrupt.
// - in no-resource every frame is dropped until software restarts.
// - reception outcome goes in the low 16 bits of word zero.
// - the link word at offset 04h gives the next descriptor offset.
// - next descriptor address is receive base plus link offset.
// - a link back to the first descriptor makes a ring.
// - size at 0Ch is data capacity, excluding any header area.
// - frame data is stored contiguously right after the size word; an honoured header descriptor starts it hdr_size bytes later.
// - data-done is set after all frame data is written.
// - count-valid is set when the byte count is written.
// - actual count holds the bytes stored in the data area.
// - status bit 9 is set when the frame exceeds the buffer.
//
// The address map and the Wishbone register port were chosen for this implementation.
module rdd_receive_dma
  import rdd_pkg::*;
#(
  parameter int CNT_BITS = CNT_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // host memory master
  output logic             mem_cyc_o,
  output logic             mem_stb_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_adr_o,
  output logic [3:0]       mem_sel_o,
  output logic [31:0]      mem_dat_o,
  input  wire logic [31:0] mem_dat_i,
  input  wire logic        mem_ack_i,
  // received frame bytes
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_last_i,
  input  wire logic        rx_err_i,
  output logic             rx_ready_o,
  output logic             no_resource_o
);
  rdd_state_t          state;
  logic [31:0]         rx_base;
  logic [31:0]         first_off;
  logic [CNT_BITS-1:0] hdr_size;
  logic                hdr_valid;
  logic                pend_start;
  logic                pend_resume;
  logic [15:0]         frames;
  logic [15:0]         drops;
  logic [31:0]         desc;
  logic [31:0]         link;
  logic                d_last;
  logic                d_susp;
  logic                d_hdr;
  logic [CNT_BITS-1:0] cap;
  logic [CNT_BITS-1:0] cnt;
  logic [31:0]         wptr;
  logic                f_err;
  logic                f_ovf;
  logic                mid;
  logic                acc;
  logic                keep;
  logic                drop_st;
  logic                wr_acc;
  logic [31:0]         wb_merged;
  logic [31:0]         wb_cur;
  logic [31:0]         data_base;
  logic [31:0]         next_adr;
  logic [31:0]         next_dat;
  logic [3:0]          next_sel;
  logic                next_we;
  logic                mem_done;
  logic                pk_valid;
  logic                pk_last;
  logic [31:0]         pk_word;
  logic [3:0]          pk_sel;
  logic                pk_almost;
  logic                pk_pop;

  assign acc      = rx_valid_i && rx_ready_o;
  assign drop_st  = (state == ST_IDLE) || (state == ST_SUSP) || (state == ST_NORES);
  assign keep     = (state == ST_RECV) && (cnt < cap);
  assign mem_done = mem_cyc_o && mem_ack_i;
  assign wr_acc   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign pk_pop   = pk_valid && ((state == ST_RECV && pk_sel == '0)
                    || (state == ST_WR_DATA && mem_done));

  ////////////////////////////////////////////////////////////////////////
  // register slave
  always_comb begin
    case (wb_adr_i)
      REG_BASE:  wb_cur = rx_base;
      REG_FIRST: wb_cur = first_off;
      REG_HDR:   wb_cur = 32'(hdr_size);
      default:   wb_cur = '0;
    endcase
    for (int b = 0; b < 4; b++) begin
      wb_merged[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : wb_cur[b*8 +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
        REG_CTRL:   wb_dat_o <= {30'h0000_0000, pend_resume, pend_start};
        REG_BASE:   wb_dat_o <= rx_base;
        REG_FIRST:  wb_dat_o <= first_off;
        REG_HDR:    wb_dat_o <= {hdr_valid, 31'(hdr_size)};
        REG_STATE:  wb_dat_o <= {30'h0000_0000, (state == ST_IDLE) ? RX_IDLE :
                                 (state == ST_SUSP) ? RX_SUSPENDED :
                                 (state == ST_NORES) ? RX_NO_RES : RX_READY};
        REG_FRAMES: wb_dat_o <= {16'h0000, frames};
        REG_DROPS:  wb_dat_o <= {16'h0000, drops};
        default:    wb_dat_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_base   <= '0;
      first_off <= '0;
      hdr_size  <= '0;
      hdr_valid <= 1'b0;
    end else if (wr_acc) begin
      if (wb_adr_i == REG_BASE) rx_base <= wb_merged;
      if (wb_adr_i == REG_FIRST) first_off <= wb_merged;
      if (wb_adr_i == REG_HDR) hdr_size <= wb_merged[CNT_BITS-1:0];
      if (wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_HDR_LOAD]) begin
        hdr_valid <= 1'b1;
      end
    end
  end

  // start and resume commands wait until no frame is half dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_start  <= 1'b0;
      pend_resume <= 1'b0;
    end else if (wr_acc && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      pend_start  <= wb_dat_i[CTRL_START] | (pend_start & !wb_dat_i[CTRL_ABORT]);
      pend_resume <= wb_dat_i[CTRL_RESUME] | (pend_resume & !wb_dat_i[CTRL_ABORT]);
    end else if (drop_st && !mid && !(acc && !rx_last_i)) begin
      if (pend_start) pend_start <= 1'b0;
      else if (state == ST_SUSP) pend_resume <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory request set-up
  assign data_base = desc + DESC_DATA_OFF + ((d_hdr && hdr_valid) ? 32'(hdr_size) : '0);

  always_comb begin
    next_adr = desc;
    next_dat = '0;
    next_sel = SEL_ALL;
    next_we  = 1'b0;
    case (state)
      ST_RD_LINK:  next_adr = desc + DESC_LINK_OFF;
      ST_RD_SIZE:  next_adr = desc + DESC_SIZE_OFF;
      ST_WR_DATA: begin
        next_adr = data_base + wptr;
        next_dat = pk_word;
        next_sel = pk_sel;
        next_we  = 1'b1;
      end
      ST_WR_COUNT: begin
        next_adr = desc + DESC_SIZE_OFF;
        next_dat = '0;
        next_dat[BIT_DATA_DONE] = 1'b1;
        next_dat[BIT_CNT_VALID] = 1'b1;
        next_dat[CNT_BITS-1:0]  = cnt;
        next_sel = SEL_LOW_HALF;
        next_we  = 1'b1;
      end
      ST_WR_STAT: begin
        next_dat = '0;
        next_dat[BIT_DONE]    = 1'b1;
        next_dat[BIT_OK]      = !f_err && !f_ovf;
        next_dat[BIT_NO_ROOM] = f_ovf;
        next_dat[BIT_RX_ERR]  = f_err;
        next_sel = SEL_LOW_HALF;
        next_we  = 1'b1;
      end
      default: next_adr = desc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_cyc_o <= 1'b0;
      mem_stb_o <= 1'b0;
      mem_we_o  <= 1'b0;
      mem_adr_o <= '0;
      mem_sel_o <= '0;
      mem_dat_o <= '0;
    end else if (mem_done) begin
      mem_cyc_o <= 1'b0;
      mem_stb_o <= 1'b0;
    end else if (!mem_cyc_o && (state inside {ST_RD_CMD, ST_RD_LINK, ST_RD_SIZE,
                                 ST_WR_DATA, ST_WR_COUNT, ST_WR_STAT})) begin
      mem_cyc_o <= 1'b1;
      mem_stb_o <= 1'b1;
      mem_we_o  <= next_we;
      mem_adr_o <= next_adr;
      mem_sel_o <= next_sel;
      mem_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive unit sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= ST_IDLE;
      desc          <= '0;
      link          <= '0;
      d_last        <= 1'b0;
      d_susp        <= 1'b0;
      d_hdr         <= 1'b0;
      cap           <= '0;
      no_resource_o <= 1'b0;
    end else begin
      no_resource_o <= 1'b0;
      case (state)
        ST_IDLE, ST_SUSP, ST_NORES: begin
          if (wr_acc && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_ABORT]) begin
            state <= ST_IDLE;
          end else if (!mid && !(acc && !rx_last_i)) begin
            if (pend_start) begin
              desc  <= rx_base + first_off;
              state <= ST_RD_CMD;
            end else if (pend_resume && state == ST_SUSP) begin
              desc  <= rx_base + link;
              state <= ST_RD_CMD;
            end
          end
        end
        ST_RD_CMD: if (mem_done) begin
          d_last <= mem_dat_i[BIT_LAST];
          d_susp <= mem_dat_i[BIT_SUSPEND];
          d_hdr  <= mem_dat_i[BIT_HEADER];
          state  <= ST_RD_LINK;
        end
        ST_RD_LINK: if (mem_done) begin
          link  <= mem_dat_i;
          state <= ST_RD_SIZE;
        end
        ST_RD_SIZE: if (mem_done) begin
          cap   <= mem_dat_i[SIZE_LSB +: CNT_BITS];
          state <= ST_RECV;
        end
        ST_RECV: if (pk_valid) begin
          state <= (pk_sel != '0) ? ST_WR_DATA : ST_WR_COUNT;
        end
        ST_WR_DATA: if (mem_done) begin
          state <= pk_last ? ST_WR_COUNT : ST_RECV;
        end
        ST_WR_COUNT: if (mem_done) begin
          state <= ST_WR_STAT;
        end
        ST_WR_STAT: if (mem_done) begin
          if (d_last) begin
            state         <= ST_NORES;
            no_resource_o <= 1'b1;
          end else if (d_susp) begin
            state <= ST_SUSP;
          end else begin
            desc  <= rx_base + link;
            state <= ST_RD_CMD;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame bookkeeping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= '0;
      wptr  <= '0;
      f_err <= 1'b0;
      f_ovf <= 1'b0;
    end else if (state == ST_RD_SIZE) begin
      cnt   <= '0;
      wptr  <= '0;
      f_err <= 1'b0;
      f_ovf <= 1'b0;
    end else if (state == ST_RECV && acc) begin
      if (keep) cnt <= cnt + 1'b1;
      if (!keep) f_ovf <= 1'b1;
      if (rx_err_i) f_err <= 1'b1;
    end else if (state == ST_WR_DATA && mem_done) begin
      wptr <= wptr + 32'h0000_0004;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ready_o <= 1'b0;
      mid        <= 1'b0;
      frames     <= '0;
      drops      <= '0;
    end else begin
      if (acc) mid <= !rx_last_i;
      if (state == ST_WR_STAT && mem_done) frames <= frames + 1'b1;
      if (drop_st && acc && rx_last_i) drops <= drops + 1'b1;
      if (drop_st) begin
        rx_ready_o <= 1'b1;
      end else if (state == ST_RD_SIZE) begin
        rx_ready_o <= mem_done;
      end else if (state == ST_RECV && acc && (rx_last_i || (keep && pk_almost))) begin
        rx_ready_o <= 1'b0;
      end else if (state == ST_WR_DATA && mem_done) begin
        rx_ready_o <= !pk_last;
      end else if (state != ST_RECV) begin
        rx_ready_o <= 1'b0;
      end
    end
  end

  rdd_packer #(
    .LANES(4)
  ) u_packer (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (acc && state == ST_RECV),
    .in_data_i   (rx_data_i),
    .in_keep_i   (keep),
    .in_last_i   (rx_last_i),
    .out_ready_i (pk_pop),
    .out_valid_o (pk_valid),
    .out_last_o  (pk_last),
    .out_word_o  (pk_word),
    .out_sel_o   (pk_sel),
    .almost_o    (pk_almost)
  );
endmodule

// *** tb/rdd_receive_dma_checker.sv ***
// Purpose: port-level checks of the receive descriptor dma
// Assumes: header size load never issued, register writes use all lanes
// Notes:   descriptor address, flags and size are tracked from fetch reads
module rdd_receive_dma_checker
  import rdd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_cyc_o,
  input wire logic        mem_stb_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_adr_o,
  input wire logic [3:0]  mem_sel_o,
  input wire logic [31:0] mem_dat_o,
  input wire logic [31:0] mem_dat_i,
  input wire logic        mem_ack_i,
  input wire logic        no_resource_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0]  rd_n;
  logic [31:0] d_adr, cmd_w, link_w, base_r, first_r;
  logic [13:0] size_w;
  logic        have_link, cnt_done, nores, fetched;
  wire rd_ack  = mem_cyc_o && mem_stb_o && !mem_we_o && mem_ack_i;
  wire wr_req  = mem_cyc_o && mem_stb_o && mem_we_o;
  wire wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire cnt_wr  = wr_req && (mem_adr_o == d_adr + DESC_SIZE_OFF);
  wire stat_wr = wr_req && (mem_adr_o == d_adr);
  ////////////////////////////////////////////////////////////
  // fetch tracking: three reads per descriptor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_n <= 2'h0;
    end else if (rd_ack) begin
      rd_n <= (rd_n == 2'h2) ? 2'h0 : rd_n + 2'h1;
      if (rd_n == 2'h0) begin
        d_adr <= mem_adr_o;
        cmd_w <= mem_dat_i;
      end
      if (rd_n == 2'h1) link_w <= mem_dat_i;
      if (rd_n == 2'h2) size_w <= mem_dat_i[29:16];
    end
  end
  always_ff @(posedge clk_i) begin
    if (wb_wr && wb_adr_i == REG_BASE) base_r <= wb_dat_i;
    if (wb_wr && wb_adr_i == REG_FIRST) first_r <= wb_dat_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_link <= 1'b0;
      cnt_done  <= 1'b0;
      nores     <= 1'b0;
      fetched   <= 1'b0;
    end else begin
      if (rd_ack && rd_n == 2'h1) have_link <= !cmd_w[BIT_LAST];
      if (rd_ack && rd_n == 2'h2) fetched <= 1'b1;
      if (wr_req && mem_ack_i) fetched <= 1'b0;
      if (cnt_wr && mem_ack_i) cnt_done <= 1'b1;
      if (stat_wr && mem_ack_i) cnt_done <= 1'b0;
      if (no_resource_o) nores <= 1'b1;
      if (wb_wr && wb_adr_i == REG_CTRL) begin
        nores <= 1'b0;
        if (wb_dat_i[CTRL_START]) have_link <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  a_next_desc: assert property (rd_ack && rd_n == 2'h0 |->
    mem_adr_o == base_r + (have_link ? link_w : first_r)) else $error("descriptor address");
  a_stat_done: assert property (stat_wr |->
    mem_dat_o[BIT_DONE] && mem_sel_o == SEL_LOW_HALF) else $error("status word");
  a_count_flags: assert property (cnt_wr |-> mem_dat_o[BIT_DATA_DONE] &&
    mem_dat_o[BIT_CNT_VALID] && mem_sel_o == SEL_LOW_HALF) else $error("count flags");
  a_count_first: assert property (stat_wr |-> cnt_done) else $error("status early");
  a_ok_clean: assert property (stat_wr && mem_dat_o[BIT_OK] |->
    !mem_dat_o[BIT_NO_ROOM] && !mem_dat_o[BIT_RX_ERR]) else $error("ok with fault");
  a_count_fits: assert property (cnt_wr |-> mem_dat_o[13:0] <= size_w)
    else $error("count above size");
  a_nores_pulse: assert property (stat_wr && mem_ack_i && cmd_w[BIT_LAST] |->
    ##[1:4] no_resource_o) else $error("no resource pulse missing");
  a_nores_quiet: assert property (nores |-> !wr_req) else $error("write while halted");
  a_data_start: assert property (wr_req && fetched && !cnt_wr |->
    mem_adr_o == d_adr + DESC_DATA_OFF) else $error("data start address");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("register ack timing");
  a_mem_hold: assert property (mem_cyc_o && !mem_ack_i |=>
    mem_cyc_o && $stable(mem_adr_o) && $stable(mem_dat_o)) else $error("request moved");
endmodule
bind rdd_receive_dma rdd_receive_dma_checker i_rdd_receive_dma_checker (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
  .mem_cyc_o, .mem_stb_o, .mem_we_o, .mem_adr_o, .mem_sel_o, .mem_dat_o, .mem_dat_i,
  .mem_ack_i, .no_resource_o
);

// *** tb/rdd_mem_model.sv ***
// Purpose: host memory answering the dma's classic wishbone master
// Assumes: 1 KiB of byte addressed words, descriptors built by the bench
// Notes:   idle read data toggles so stale values are never mistaken for data
module rdd_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        slow_i,
  output logic [31:0]      dat_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [1:0]  wait_n;
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    dat_o <= rst_i ? 32'h0000_0000 : ~dat_o;
    wait_n <= 2'h0;
    if (!rst_i && cyc_i && stb_i && !ack_o) begin
      if (!slow_i || wait_n == 2'h3) begin
        ack_o <= 1'b1;
        dat_o <= mem[adr_i[9:2]];
        for (int b = 0; b < 4; b++) begin
          if (we_i && sel_i[b]) mem[adr_i[9:2]][8 * b +: 8] <= dat_i[8 * b +: 8];
        end
      end else begin
        wait_n <= wait_n + 2'h1;
      end
    end
  end
endmodule

// *** tb/test_receive_descriptor_dma.sv ***
// Purpose: self-checking bench for the receive descriptor dma
// Assumes: memory model on the far side, registers over classic wishbone
// Notes:   descriptors are written straight into the model memory
module test_receive_descriptor_dma
  import rdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BASE = 32'h0000_0100;
  logic        clk_i = 1'b0;
  logic        rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o;
  logic        mem_ack_i, rx_valid_i, rx_last_i, rx_err_i, rx_ready_o, no_resource_o, slow;
  logic [3:0]  wb_sel_i, mem_sel_o;
  logic [7:0]  wb_adr_i, rx_data_i;
  logic [31:0] wb_dat_i, wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i, seed, q;
  int          err_count, num_checks;
  logic [7:0]  fb [$];
  always #5 clk_i = ~clk_i;
  rdd_receive_dma i_rdd_receive_dma (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_cyc_o, .mem_stb_o,
    .mem_we_o, .mem_adr_o, .mem_sel_o, .mem_dat_o, .mem_dat_i, .mem_ack_i, .rx_valid_i,
    .rx_data_i, .rx_last_i, .rx_err_i, .rx_ready_o, .no_resource_o);
  rdd_mem_model i_rdd_mem_model (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(mem_cyc_o),
    .stb_i(mem_stb_o), .we_i(mem_we_o), .adr_i(mem_adr_o), .sel_i(mem_sel_o),
    .dat_i(mem_dat_o), .slow_i(slow), .dat_o(mem_dat_i), .ack_o(mem_ack_i));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic set_desc(input int d, input logic last, input logic susp, input logic hdr,
                          input logic [31:0] link, input logic [13:0] size);
    int w;
    w = (BASE + d) >> 2;
    i_rdd_mem_model.mem[w] = {last, susp, 9'h000, hdr, 1'b0, 19'h0_0000};
    i_rdd_mem_model.mem[w + 1] = link;
    i_rdd_mem_model.mem[w + 3] = {2'h0, size, 16'h0000};
  endtask
  task automatic send_frame(input int n, input int err_at);
    fb.delete();
    for (int i = 0; i < n; i++) begin
      fb.push_back(8'($random(seed)));
      rx_valid_i <= 1'b1;
      rx_data_i  <= fb[i];
      rx_last_i  <= (i == n - 1);
      rx_err_i   <= (i == err_at);
      slow       <= seed[5];
      do @(posedge clk_i); while (rx_ready_o !== 1'b1);
    end
    rx_valid_i <= 1'b0;
    rx_last_i  <= 1'b0;
    rx_err_i   <= 1'b0;
  endtask
  function automatic logic [15:0] exp_stat(input int n, input int size, input logic err);
    exp_stat = 16'h0000;
    exp_stat[BIT_DONE] = 1'b1;
    exp_stat[BIT_OK] = (n <= size) && !err;
    exp_stat[BIT_NO_ROOM] = n > size;
    exp_stat[BIT_RX_ERR] = err;
  endfunction
  task automatic check_frame(input int d, input int n, input int size, input logic err);
    int w;
    int m;
    logic [31:0] a;
    w = (BASE + d) >> 2;
    m = (n > size) ? size : n;
    for (int k = 0; k < 500 && i_rdd_mem_model.mem[w][BIT_DONE] !== 1'b1; k++) @(posedge clk_i);
    chk(i_rdd_mem_model.mem[w][15:0], exp_stat(n, size, err));
    chk(i_rdd_mem_model.mem[w + 3], {2'h0, 14'(size), 2'h3, 14'(m)});
    for (int i = 0; i < m; i++) begin
      a = BASE + 32'(d) + DESC_DATA_OFF + 32'(i);
      chk(i_rdd_mem_model.mem[a >> 2][8 * a[1:0] +: 8], fb[i]);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    seed = 32'ha597_f6b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, rx_last_i, rx_err_i, slow} = 7'h00;
    {wb_adr_i, rx_data_i, wb_dat_i} = 48'h0000_0000_0000;
    wb_sel_i = SEL_ALL;
    rst_i = 1'b1;
    for (int i = 0; i < 256; i++) i_rdd_mem_model.mem[i] = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    set_desc(0, 1'b0, 1'b0, 1'b1, 32'h0000_0040, 14'h0010);
    set_desc(64, 1'b0, 1'b1, 1'b0, 32'h0000_0000, 14'h0008);
    wb_rw(1'b1, REG_BASE, BASE);
    wb_rw(1'b1, REG_FIRST, 32'h0000_0000);
    wb_rw(1'b1, 8'h1C, 32'hFFFF_FFFF);
    wb_rw(1'b0, 8'h1C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb_rw(1'b1, REG_CTRL, 32'h0000_0001);
    wb_rw(1'b0, REG_STATE, 32'h0000_0000);
    chk(q, {30'h0, RX_READY});
    send_frame(10, -1);
    check_frame(0, 10, 16, 1'b0);
    send_frame(11, -1);
    check_frame(64, 11, 8, 1'b0);
    repeat (4) @(posedge clk_i);
    wb_rw(1'b0, REG_STATE, 32'h0000_0000);
    chk(q, {30'h0, RX_SUSPENDED});
    set_desc(0, 1'b1, 1'b0, 1'b0, 32'h0000_0040, 14'h0010);
    wb_rw(1'b1, REG_CTRL, 32'h0000_0002);
    send_frame(6, -1);
    check_frame(0, 6, 16, 1'b0);
    repeat (4) @(posedge clk_i);
    wb_rw(1'b0, REG_STATE, 32'h0000_0000);
    chk(q, {30'h0, RX_NO_RES});
    send_frame(5, -1);
    repeat (8) @(posedge clk_i);
    wb_rw(1'b0, REG_DROPS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    chk(i_rdd_mem_model.mem[67][13:0], 14'h0006);
    set_desc(0, 1'b0, 1'b0, 1'b0, 32'h0000_0040, 14'h0010);
    set_desc(64, 1'b1, 1'b0, 1'b0, 32'h0000_0000, 14'h0008);
    wb_rw(1'b1, REG_CTRL, 32'h0000_0001);
    send_frame(7, 2);
    check_frame(0, 7, 16, 1'b1);
    send_frame(8, -1);
    check_frame(64, 8, 8, 1'b0);
    repeat (4) @(posedge clk_i);
    wb_rw(1'b1, REG_CTRL, 32'h0000_0004);
    wb_rw(1'b0, REG_STATE, 32'h0000_0000);
    chk(q, {30'h0, RX_IDLE});
    wrap_up();
  end
endmodule
